// ### rtl/csf_map.vh
// Register map and field layout of the control structure field access unit.
// Assumes a 32-bit AHB-Lite master and one aligned word per register.
//
// Summary of operation
// RULE1 - In wide mode an encoding operand with bits above 31 set fails.
// RULE2 - Software keeps encoding bits 31:15 and bit 12 zero.
// RULE3 - Width code is encoding bits 14:13: 16, 64, 32, natural.
// RULE4 - Natural width holds 64 bits with the extension, else 32 bits.
// RULE5 - Type code is encoding bits 11:10: control, read-only, guest, host.
// RULE6 - Encoding bits 9:1 index fields sharing width and type; the unit decodes bits 4:1 only and fails if bits 9:5 are set.
// RULE7 - High access only on 64-bit fields; it reaches bits 63:32 only.
// RULE8 - 16-bit read returns value in bits 15:0, rest zero.
// RULE9 - 16-bit write stores source bits 15:0 only.
// RULE10 - 32-bit read returns bits 31:0; wide mode zeroes bits 63:32.
// RULE11 - 32-bit write stores source bits 31:0; upper source ignored.
// RULE12 - Outside wide mode full read of wide field returns bits 31:0.
// RULE13 - Outside wide mode full write loads low half, clears high half.
// RULE14 - In wide mode full access of wide fields moves all 64 bits.
// RULE15 - High read returns field bits 63:32 in bits 31:0, rest zero.
// RULE16 - High write copies source bits 31:0 into field bits 63:32.
// RULE17 - Software writes full half before high half outside wide mode.
// RULE18 - Pointer-referenced structures are not reachable by field access.
// RULE19 - Enable pointer must be 4-KByte aligned, bits 11:0 zero.
// RULE20 - Enable pointer sets no bits beyond physical address width.
// RULE21 - Software stores revision id in region, one region per processor.
// RULE22 - Structure clear initialises bookkeeping so region loads safely.
// RULE23 - Reserved bits or misused high access fail with no field change.
`ifndef CSF_MAP_VH
`define CSF_MAP_VH
// Word indices, byte address is four times the index
`define CSF_IDX_CTRL    6'h00
`define CSF_IDX_ENC_LO  6'h01
`define CSF_IDX_ENC_HI  6'h02
`define CSF_IDX_SRC_LO  6'h03
`define CSF_IDX_SRC_HI  6'h04
`define CSF_IDX_PTR_LO  6'h05
`define CSF_IDX_PTR_HI  6'h06
`define CSF_IDX_CMD     6'h07
`define CSF_IDX_STATUS  6'h08
`define CSF_IDX_DST_LO  6'h09
`define CSF_IDX_DST_HI  6'h0a
// Control bits
`define CSF_CTRL_WIDE   0
`define CSF_CTRL_EXT64  1
`define CSF_CTRL_RST    2'h0
// Status bits
`define CSF_ST_FAIL     0
`define CSF_ST_ENABLED  1
// Command codes
`define CSF_CMD_READ    3'h0
`define CSF_CMD_WRITE   3'h1
`define CSF_CMD_CLEAR   3'h2
`define CSF_CMD_ENABLE  3'h3
`define CSF_CMD_DISABLE 3'h4
// Width codes
`define CSF_W16         2'h0
`define CSF_W64         2'h1
`define CSF_W32         2'h2
`define CSF_WNAT        2'h3
// Lowest pointer-high bit beyond a 36-bit physical address
`define CSF_PA_HI_LSB   4
`endif

// ### rtl/csf_field_access.v
// Field access unit for the virt_control_structure, AHB-Lite slave.
// Decodes field encodings and formats field reads and writes by width.
// Assumes one AHB-Lite master, single word transfers, sys_clk domain only.
// Assumes ce freezes every flop, bus state included.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "csf_map.vh"
`default_nettype none
module csf_field_access
(
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp
);

  reg  [1:0]   ctrl_r;
  reg  [31:0]  encLo_r;
  reg  [31:0]  encHi_r;
  reg  [63:0]  src_r;
  reg  [63:0]  ptr_r;
  reg  [63:0]  dst_r;
  reg          fail_r;
  reg          enabled_r;
  reg  [5:0]   aIdx_r;
  reg          wrPend_r;
  reg          rdPend_r;
  reg  [255:0] valid_r;
  reg  [63:0]  fieldMem [0:255];

  reg  [63:0]  dst_nxt;
  reg          fail_nxt;
  reg          fieldWe;
  reg  [63:0]  fieldWd;
  reg  [63:0]  rdFmt;
  reg  [63:0]  wrFmt;
  reg  [31:0]  rdMux;

  wire         accept;
  wire         rdStart;
  wire         wrStart;
  wire         opGo;
  wire [2:0]   opCode;
  wire         cmdRead;
  wire         cmdWrite;
  wire         cmdClear;
  wire         cmdEnable;
  wire         cmdDisable;
  wire         wide;
  wire         ext64;
  wire [1:0]   wCode;
  wire [1:0]   tCode;
  wire [3:0]   fIdx;
  wire         highAcc;
  wire         resvBad;
  wire         highBad;
  wire         idxBad;
  wire         opndBad;
  wire         encBad;
  wire [7:0]   fAddr;
  wire [63:0]  fieldRd;
  wire         fieldOp;
  wire         ptrMisal;
  wire         ptrWide;
  wire         ptrBad;
  wire [31:0]  ctrlWord;
  wire [31:0]  statusWord;

  // Bus request taken and command strobe
  assign accept     = hsel & htrans[1] & hready;
  assign rdStart    = accept & !hwrite;
  assign wrStart    = accept & hwrite;
  assign opGo       = wrPend_r & (aIdx_r == `CSF_IDX_CMD);
  assign opCode     = hwdata[2:0];
  assign cmdRead    = opGo & (opCode == `CSF_CMD_READ);
  assign cmdWrite   = opGo & (opCode == `CSF_CMD_WRITE);
  assign cmdClear   = opGo & (opCode == `CSF_CMD_CLEAR);
  assign cmdEnable  = opGo & (opCode == `CSF_CMD_ENABLE);
  assign cmdDisable = opGo & (opCode == `CSF_CMD_DISABLE);
  assign fieldOp    = cmdRead | cmdWrite;

  // Mode and encoding fields
  assign ext64      = ctrl_r[`CSF_CTRL_EXT64];
  assign wide       = ctrl_r[`CSF_CTRL_WIDE] & ext64;
  assign wCode      = encLo_r[14:13]; // see RULE3
  assign tCode      = encLo_r[11:10]; // see RULE5
  assign fIdx       = encLo_r[4:1]; // see RULE6
  assign highAcc    = encLo_r[0];
  assign ctrlWord   = {30'h0, ctrl_r};
  assign statusWord = {30'h0, enabled_r, fail_r};

  // Reasons for a field operation to fail
  assign resvBad = (encLo_r[31:15] != 17'h00000) | encLo_r[12]; // see RULE23
  assign highBad = highAcc & (wCode != `CSF_W64); // see RULE7 see RULE23
  assign idxBad  = encLo_r[9:5] != 5'h00;
  assign opndBad = wide & (encHi_r != 32'h0); // see RULE1
  assign encBad  = resvBad | highBad | idxBad | opndBad;

  // Entry selected by width, type and index only; nothing else reachable
  assign fAddr   = {wCode, tCode, fIdx}; // see RULE18
  assign fieldRd = valid_r[fAddr] ? fieldMem[fAddr] : 64'h0; // see RULE22

  // Alignment and physical width of the enable pointer
  assign ptrMisal = ptr_r[11:0] != 12'h000; // see RULE19
  assign ptrWide  = ext64 ? (ptr_r[63:32+`CSF_PA_HI_LSB] != 28'h0)
                          : (ptr_r[63:32] != 32'h0); // see RULE20
  assign ptrBad   = ptrMisal | ptrWide;

  // Read formatting by width, access type and mode
  always @*
  begin
    rdFmt = 64'h0;
    case (wCode)
      `CSF_W16:
        rdFmt = {48'h0, fieldRd[15:0]}; // see RULE8
      `CSF_W32:
        rdFmt = {32'h0, fieldRd[31:0]}; // see RULE10
      default:
      begin
        if (highAcc)
          rdFmt = {32'h0, fieldRd[63:32]}; // see RULE15
        else if (wide)
          rdFmt = fieldRd; // see RULE14 see RULE4
        else
          rdFmt = {32'h0, fieldRd[31:0]}; // see RULE12 see RULE4
      end
    endcase
  end

  // Write formatting; the high access keeps the low half
  always @*
  begin
    wrFmt = 64'h0;
    case (wCode)
      `CSF_W16:
        wrFmt = {48'h0, src_r[15:0]}; // see RULE9
      `CSF_W32:
        wrFmt = {32'h0, src_r[31:0]}; // see RULE11
      default:
      begin
        if (highAcc)
          wrFmt = {src_r[31:0], fieldRd[31:0]}; // see RULE16
        else if (wide)
          wrFmt = src_r; // see RULE14 see RULE4
        else
          wrFmt = {32'h0, src_r[31:0]}; // see RULE13 see RULE4
      end
    endcase
  end

  // Operation outcome; a failed operation leaves fields and result alone
  always @*
  begin
    dst_nxt  = dst_r;
    fail_nxt = fail_r;
    fieldWe  = 1'b0;
    fieldWd  = 64'h0;
    if (fieldOp)
    begin
      fail_nxt = !enabled_r | encBad; // see RULE1 see RULE23
      if (!fail_nxt && cmdRead)
        dst_nxt = rdFmt;
      if (!fail_nxt && cmdWrite)
      begin
        fieldWe = 1'b1;
        fieldWd = wrFmt;
      end
    end
    else if (cmdEnable)
      fail_nxt = ptrBad; // see RULE19 see RULE20
    else if (opGo)
      fail_nxt = 1'b0;
  end

  // Register read mux
  always @*
  begin
    case (aIdx_r)
      `CSF_IDX_CTRL:   rdMux = ctrlWord;
      `CSF_IDX_ENC_LO: rdMux = encLo_r;
      `CSF_IDX_ENC_HI: rdMux = encHi_r;
      `CSF_IDX_SRC_LO: rdMux = src_r[31:0];
      `CSF_IDX_SRC_HI: rdMux = src_r[63:32];
      `CSF_IDX_PTR_LO: rdMux = ptr_r[31:0];
      `CSF_IDX_PTR_HI: rdMux = ptr_r[63:32];
      `CSF_IDX_STATUS: rdMux = statusWord;
      `CSF_IDX_DST_LO: rdMux = dst_r[31:0];
      `CSF_IDX_DST_HI: rdMux = dst_r[63:32];
      default:         rdMux = 32'h0;
    endcase
  end

  // Field storage, guarded by the valid bits
  always @(posedge sys_clk)
  begin
    if (ce && fieldWe)
      fieldMem[fAddr] <= fieldWd;
  end

  // One valid flag per stored field; clear drops them all
  // Set and clear never coincide: they come from different commands
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi = gi + 1)
    begin : g_valid
      always @(posedge sys_clk)
      begin
        if (!rst_b)
          valid_r[gi] <= 1'b0;
        else if (ce && cmdClear)
          valid_r[gi] <= 1'b0; // see RULE22
        else if (ce && fieldWe && ({24'h0, fAddr} == gi))
          valid_r[gi] <= 1'b1;
      end
    end
  endgenerate

  // Bus slave handshake: no wait on writes, one wait state on reads
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
      aIdx_r    <= 6'h0;
      wrPend_r  <= 1'b0;
      rdPend_r  <= 1'b0;
    end
    else if (ce)
    begin
      hresp    <= 1'b0;
      wrPend_r <= wrStart;
      if (accept)
        aIdx_r <= haddr[7:2];
      if (rdStart)
      begin
        rdPend_r  <= 1'b1;
        hreadyout <= 1'b0;
      end
      else if (rdPend_r)
      begin
        hrdata    <= rdMux;
        hreadyout <= 1'b1;
        rdPend_r  <= 1'b0;
      end
    end
  end

  // Software-visible operand registers
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl_r  <= `CSF_CTRL_RST;
      encLo_r <= 32'h0;
      encHi_r <= 32'h0;
      src_r   <= 64'h0;
      ptr_r   <= 64'h0;
    end
    else if (ce && wrPend_r)
    begin
      case (aIdx_r)
        `CSF_IDX_CTRL:   ctrl_r <= hwdata[1:0];
        `CSF_IDX_ENC_LO: encLo_r <= hwdata;
        `CSF_IDX_ENC_HI: encHi_r <= hwdata;
        `CSF_IDX_SRC_LO: src_r[31:0] <= hwdata;
        `CSF_IDX_SRC_HI: src_r[63:32] <= hwdata;
        `CSF_IDX_PTR_LO: ptr_r[31:0] <= hwdata;
        `CSF_IDX_PTR_HI: ptr_r[63:32] <= hwdata;
        default:         ;
      endcase
    end
  end

  // Result, failure flag and enabled state
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      dst_r     <= 64'h0;
      fail_r    <= 1'b0;
      enabled_r <= 1'b0;
    end
    else if (ce)
    begin
      dst_r  <= dst_nxt;
      fail_r <= fail_nxt;
      if (cmdEnable && !ptrBad)
        enabled_r <= 1'b1; // see RULE19 see RULE20
      else if (cmdDisable)
        enabled_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### test/csf_sw_master.sv
// Software master model: register and field accesses over AHB-Lite.
// Assumes the slave's hreadyout comes back as hready; word transfers only.
`default_nettype none
module csf_sw_master
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output wire logic        hsel,
  output wire logic [2:0]  hsize,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  assign hsel = 1'b1;
  assign hsize = 3'h2;
  initial {haddr, htrans, hwrite, hwdata} = 67'h0;
  // Address phase, then data phase, each held until hready is seen high
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (!hready);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### test/csf_monitor.sv
// Bus checker of the field access unit, bound to its top module.
// Assumes hready is the unit's own hreadyout.
`default_nettype none
module csf_monitor
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_r, wr_r;
  logic [7:0] adr_r;
  logic [1:0] ctl_r;
  wire        take = hsel && htrans[1] && hready && ce;
  wire        rdEnd = rd_r && hreadyout;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk)
    if (!rst_b)
      {rd_r, wr_r, adr_r, ctl_r} <= 12'h0;
    else if (ce)
    begin
      if (hready)
        {rd_r, wr_r, adr_r} <= {take & !hwrite, take & hwrite, haddr[7:0]};
      if (wr_r && adr_r == 8'h00)
        ctl_r <= hwdata[1:0];
    end
  property p_ok; hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("bad response");
  property p_rdW; take && !hwrite |=> !hreadyout; endproperty
  a_rdW: assert property (p_rdW) else $error("read had no wait");
  property p_rdE; !hreadyout && ce |=> hreadyout; endproperty
  a_rdE: assert property (p_rdE) else $error("wait too long");
  property p_low; !hreadyout |-> rd_r; endproperty
  a_low: assert property (p_low) else $error("stray wait");
  property p_wrW; take && hwrite |=> hreadyout; endproperty
  a_wrW: assert property (p_wrW) else $error("write waited");
  property p_cmd; rdEnd && adr_r == 8'h1c |-> hrdata == 32'h0; endproperty
  a_cmd: assert property (p_cmd) else $error("command read back");
  property p_hi;
    rdEnd && adr_r == 8'h28 && ctl_r != 2'h3 |-> hrdata == 32'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper result not zero");
  property p_hold; $changed(hrdata) |-> $past(rd_r); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_hi: cover property (rdEnd && adr_r == 8'h28 && ctl_r == 2'h3);
  c_cmd: cover property (wr_r && adr_r == 8'h1c);
  c_b2b: cover property (rdEnd && take);
endmodule
bind csf_field_access csf_monitor mon_u (.sys_clk, .rst_b, .ce, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp);
`default_nettype wire

// ### test/test_control_structure_field_access.sv
// Bench of the field access unit, one task per scenario.
// Assumes the master model drives the bus; ce is held high except in t_freeze.
`default_nettype none
module test_control_structure_field_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sysClk, rstB, ce;
  wire         hsel, hwrite, hrdy, hresp;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  int          n_fail, check_count;
  logic [31:0] q;
  csf_sw_master sw (.sys_clk(sysClk), .hready(hrdy), .hrdata, .hsel,
    .hsize, .haddr, .htrans, .hwrite, .hwdata);
  csf_field_access dut_u (.sys_clk(sysClk), .rst_b(rstB), .ce, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy),
    .hreadyout(hrdy), .hrdata, .hresp);
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    sw.xfer(1'b0, i, 32'h0, q);
    check_count++;
    if (q !== e)
    begin
      n_fail++;
      $display("Error reg %h expected %h seen %h", i, e, q);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    sw.xfer(1'b1, i, d, q);
  endtask
  task automatic op(input logic [2:0] c, input logic [31:0] e, s,
                    l = 32'h0, h = 32'h0);
    wr(6'h03, l);
    wr(6'h04, h);
    wr(6'h01, e);
    wr(6'h07, {29'h0, c});
    rd(6'h08, s);
  endtask
  task automatic fr(input logic [31:0] e, l, h);
    op(3'h0, e, 32'h2);
    rd(6'h09, l);
    rd(6'h0a, h);
  endtask
  function automatic logic [31:0] ec(input int k);
    return 32'(k / 4 * 8192 + k % 4 * 1024 + 2);
  endfunction
  task automatic t_start;
    rd(6'h3f, 32'h0);
    op(3'h0, 32'h2002, 32'h1);
    wr(6'h00, 32'h2);
    wr(6'h06, 32'hf);
    wr(6'h05, 32'h1800);
    op(3'h3, 32'h0, 32'h1);
    wr(6'h05, 32'h1000);
    wr(6'h00, 32'h0);
    op(3'h3, 32'h0, 32'h1);
    wr(6'h00, 32'h2);
    op(3'h3, 32'h0, 32'h2);
  endtask
  task automatic t_freeze;
    ce <= 1'b0;
    wr(6'h03, 32'hdead_beef);
    ce <= 1'b1;
    rd(6'h03, 32'h0);
    rd(6'h07, 32'h0);
  endtask
  task automatic t_width;
    for (int k = 0; k < 16; k++)
      op(3'h1, ec(k), 32'h2, {16'h5a00, 16'(k)}, ~32'h0);
    op(3'h1, 32'h4004, 32'h2, 32'h77);
    for (int k = 0; k < 16; k++)
      fr(ec(k), {k < 4 ? 16'h0 : 16'h5a00, 16'(k)}, 32'h0);
    fr(32'h4004, 32'h77, 32'h0);
  endtask
  task automatic t_high;
    op(3'h1, 32'h2006, 32'h2, 32'h1111_2222);
    op(3'h1, 32'h2007, 32'h2, 32'h3333_4444);
    fr(32'h2006, 32'h1111_2222, 32'h0);
    fr(32'h2007, 32'h3333_4444, 32'h0);
    op(3'h1, 32'h2006, 32'h2, 32'h5555_6666);
    fr(32'h2007, 32'h0, 32'h0);
    op(3'h1, 32'h4007, 32'h3, 32'h1);
    op(3'h1, 32'h5006, 32'h3, 32'h1);
    fr(32'h4006, 32'h0, 32'h0);
  endtask
  task automatic t_wide;
    wr(6'h00, 32'h3);
    op(3'h1, 32'h2006, 32'h2, 32'h89ab_cdef, 32'h0123_4567);
    fr(32'h2006, 32'h89ab_cdef, 32'h0123_4567);
    op(3'h1, 32'h2007, 32'h2, 32'h2468_ace0, ~32'h0);
    fr(32'h2007, 32'h2468_ace0, 32'h0);
    op(3'h1, 32'h6006, 32'h2, 32'h1357_9bdf, 32'h8642_0eca);
    fr(32'h6006, 32'h1357_9bdf, 32'h8642_0eca);
    op(3'h1, 32'h4006, 32'h2, 32'h1, ~32'h0);
    fr(32'h4006, 32'h1, 32'h0);
    wr(6'h02, 32'h1);
    op(3'h0, 32'h4006, 32'h3);
    wr(6'h02, 32'h0);
    wr(6'h00, 32'h1);
    fr(32'h6006, 32'h1357_9bdf, 32'h0);
    op(3'h2, 32'h0, 32'h2);
    fr(32'h2006, 32'h0, 32'h0);
    op(3'h4, 32'h0, 32'h0);
    op(3'h0, 32'h2006, 32'h1);
  endtask
  initial
  begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  initial
  begin
    rstB = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge sysClk);
    rstB <= 1'b1;
    @(posedge sysClk);
    t_start;
    t_width;
    t_high;
    t_wide;
    t_freeze;
    report_and_stop;
  end
  initial
  begin
    #50us;
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
